// *** video_pkg.sv ***
package video_pkg;

  // ---------------------------------------------------------------
  // Register map (word index on the Avalon address)
  // ---------------------------------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_MEM_ADDR = 4'h2;
  localparam logic [3:0] REG_CHAR_LATCH = 4'h3;
  localparam logic [3:0] REG_ATTR_LATCH = 4'h4;
  localparam logic [3:0] REG_COMMAND = 4'h5;
  localparam logic [3:0] REG_FOUNT_ADDR = 4'h6;
  localparam logic [3:0] REG_FOUNT_DATA = 4'h7;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int CTRL_DOT_SEL = 0;
  localparam int CTRL_DOUBLE = 1;
  localparam int CTRL_COL132 = 2;
  localparam int CTRL_COLOUR_ESC = 3;
  localparam int CTRL_WIDTH_LSB = 4;
  localparam logic [7:0] CTRL_RESET = 8'h90;
  localparam logic [3:0] CELL_WIDTH_MIN = 4'h6;
  localparam int STAT_READY = 0;
  localparam int STAT_COLOUR = 1;
  localparam int STAT_FIFO_EMPTY = 2;
  localparam logic [1:0] CMD_STORE = 2'h1;
  localparam logic [1:0] CMD_LOAD = 2'h2;

  // ---------------------------------------------------------------
  // Memory and line geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int CODE_W = 8;
  localparam int LINE_W = 4;
  localparam int PIX_W = 10;
  localparam logic [9:0] LINE_PIX_FAST = 10'h320;
  localparam logic [9:0] LINE_PIX_132 = 10'h318;
  localparam logic [9:0] LINE_PIX_SLOW = 10'h2d0;
  localparam logic [9:0] LINE_PIX_DOUBLE = 10'h168;
  localparam int FIFO_DEPTH = 4;

  // ---------------------------------------------------------------
  // Dot clock rates, reduced to a fractional enable on clk
  // ---------------------------------------------------------------
  localparam int DOT_FAST_KHZ = 17600;
  localparam int DOT_SLOW_KHZ = 16000;
  localparam int DOT_GRAIN_KHZ = 1600;
  localparam logic [3:0] DOT_MOD = 4'(DOT_FAST_KHZ / DOT_GRAIN_KHZ);
  localparam logic [3:0] DOT_STEP_FAST = 4'(DOT_FAST_KHZ / DOT_GRAIN_KHZ);
  localparam logic [3:0] DOT_STEP_SLOW = 4'(DOT_SLOW_KHZ / DOT_GRAIN_KHZ);

  typedef enum logic [1:0] {
    HOST_IDLE = 2'b00,
    HOST_WAIT = 2'b01,
    HOST_ACCESS = 2'b11,
    HOST_CAPTURE = 2'b10
  } host_state_e;

  typedef struct packed {
    logic [11:0] refresh_addr;
    logic [3:0] line_num;
    logic blank;
    logic cursor;
    logic hsync;
    logic switch_colour;
  } crt_in_s;

  typedef struct packed {
    logic [7:0] dots;
    logic [7:0] attr;
    logic cursor;
    logic blank;
  } cell_s;

  localparam int CELL_W = $bits(cell_s);

endpackage : video_pkg

// *** mem_dp.sv ***
`timescale 1ns/1ps
module mem_dp #(
  parameter int AW = 12,
  parameter int DW = 8
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Read data are registered, so a read sees the array one edge later.
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule : mem_dp

// *** fifo_sync.sv ***
`timescale 1ns/1ps
module fifo_sync #(
  parameter int W = 18,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  output logic [$clog2(DEPTH):0] count
);

  localparam int PW = $clog2(DEPTH);

  logic [W-1:0] store [0:DEPTH-1];
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] rd_ptr_r;
  logic [PW:0] count_r;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = (count_r != (PW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data = store[rd_ptr_r];
  assign count = count_r;

  always_ff @(posedge clk) begin
    if (push) begin
      store[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop) rd_ptr_r <= rd_ptr_r + 1'b1;
      count_r <= count_r + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

endmodule : fifo_sync

// *** char_video.sv ***
// Added by the designer: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
// Summary of operation
// - Control bit 0 clear: 17.6 MHz dot rate, line up to 800 pixels.
// - Control bit 0 set: 16 MHz dot rate, 720 visible pixels at 80 columns.
// - 132-column mode on the fast rate uses 792 pixels per line.
// - Double width holds each pixel two dots, 360 pixels per line at the 16 MHz rate.
// - Selected dot rate drives the shifter; divided rate is the character clock.
// - Refresh address indexes separate character and attribute memories, 4096 cells.
// - Fount address is code in upper eight bits, scan line in lower four.
// - Fount holds 256 groups of 16 bytes, one group per character.
// - Fount byte leaves bit 0 first as leftmost dot, through bit 7.
// - Cells wider than eight dots repeat bit 7 in extra columns.
// - Attribute bits are delayed to line up with their dots, cursor, blanking.
// - Attribute meaning follows mono or colour, from switch or escape control.
// - In mono two general bits drive green and intensity, no visual effect.
// - The dot stream feeds TTL output and the composite source.
// - Host reaches display memory through readable, writable character and attribute latches.
// - Host memory access happens only during blanking, reported by status flags.
module char_video (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic [11:0] refresh_addr,
  input wire logic [3:0] line_num,
  input wire logic disp_blank,
  input wire logic cursor,
  input wire logic hsync,
  input wire logic switch_colour,
  output logic char_clk,
  output logic ttl_red,
  output logic ttl_green,
  output logic ttl_blue,
  output logic intensity_line,
  output logic video_dot,
  output logic composite_src
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  // The refresh address is a multi-bit word crossing by two flops; the
  // controller holds it steady for a whole character, so a torn sample
  // can only last one clk and is overwritten before the fetch uses it.
  video_pkg::crt_in_s crt_meta_r;
  video_pkg::crt_in_s crt_r;
  wire video_pkg::crt_in_s crt_pins = '{refresh_addr, line_num, disp_blank, cursor, hsync,
                                        switch_colour};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      crt_meta_r <= '0;
      crt_r <= '0;
    end else begin
      crt_meta_r <= crt_pins;
      crt_r <= crt_meta_r;
    end
  end

  // ---------------------------------------------------------------
  // Avalon slave, one wait state on every access
  // ---------------------------------------------------------------
  logic [7:0] ctrl_r;
  logic [11:0] mem_addr_r;
  logic [7:0] char_latch_r;
  logic [7:0] attr_latch_r;
  logic [11:0] fount_addr_r;
  logic ready_r;
  video_pkg::host_state_e host_r;
  logic host_load_r;
  logic fifo_empty;

  wire [31:0] be_mask = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}},
                         {8{byteenable[0]}}};
  wire [31:0] wdata_m = writedata & be_mask;
  wire access_now = (read || write) && !waitrequest;
  wire wr_now = write && !waitrequest;
  wire wr_ctrl = wr_now && (address == video_pkg::REG_CTRL) && byteenable[0];
  wire wr_maddr = wr_now && (address == video_pkg::REG_MEM_ADDR);
  wire wr_char = wr_now && (address == video_pkg::REG_CHAR_LATCH) && byteenable[0];
  wire wr_attr = wr_now && (address == video_pkg::REG_ATTR_LATCH) && byteenable[0];
  wire wr_cmd = wr_now && (address == video_pkg::REG_COMMAND) && byteenable[0];
  wire wr_faddr = wr_now && (address == video_pkg::REG_FOUNT_ADDR);
  wire wr_fdata = wr_now && (address == video_pkg::REG_FOUNT_DATA) && byteenable[0];
  wire colour_mode = crt_r.switch_colour || ctrl_r[video_pkg::CTRL_COLOUR_ESC];
  wire [31:0] status_word = {29'h0, fifo_empty, colour_mode, ready_r};

  logic [31:0] rd_mux;
  always_comb begin
    case (address)
      video_pkg::REG_CTRL: rd_mux = {24'h0, ctrl_r};
      video_pkg::REG_STATUS: rd_mux = status_word;
      video_pkg::REG_MEM_ADDR: rd_mux = {20'h0, mem_addr_r};
      video_pkg::REG_CHAR_LATCH: rd_mux = {24'h0, char_latch_r};
      video_pkg::REG_ATTR_LATCH: rd_mux = {24'h0, attr_latch_r};
      video_pkg::REG_FOUNT_ADDR: rd_mux = {20'h0, fount_addr_r};
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      waitrequest <= 1'b1;
      readdata <= 32'h0;
    end else begin
      waitrequest <= !((read || write) && waitrequest);
      if (read && waitrequest) readdata <= rd_mux;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= video_pkg::CTRL_RESET;
      mem_addr_r <= 12'h000;
      fount_addr_r <= 12'h000;
    end else begin
      if (wr_ctrl) ctrl_r <= wdata_m[7:0];
      if (wr_maddr) mem_addr_r <= wdata_m[11:0];
      if (wr_faddr) begin
        fount_addr_r <= wdata_m[11:0];
      end else if (wr_fdata) begin
        fount_addr_r <= fount_addr_r + 12'h001;
      end
    end
  end

  // ---------------------------------------------------------------
  // Host access to display memory
  // ---------------------------------------------------------------
  logic [7:0] code_q;
  logic [7:0] attr_q;
  wire cmd_ok = wr_cmd && ready_r;
  wire cmd_store = cmd_ok && (wdata_m[1:0] == video_pkg::CMD_STORE);
  wire cmd_load = cmd_ok && (wdata_m[1:0] == video_pkg::CMD_LOAD);
  wire host_in_access = (host_r == video_pkg::HOST_ACCESS);
  wire host_we = host_in_access && !host_load_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      host_r <= video_pkg::HOST_IDLE;
      host_load_r <= 1'b0;
      ready_r <= 1'b1;
      char_latch_r <= 8'h00;
      attr_latch_r <= 8'h00;
    end else begin
      if (wr_char) char_latch_r <= wdata_m[7:0];
      if (wr_attr) attr_latch_r <= wdata_m[7:0];
      case (host_r)
        video_pkg::HOST_IDLE: begin
          if (cmd_store || cmd_load) begin
            host_load_r <= cmd_load;
            ready_r <= 1'b0;
            host_r <= video_pkg::HOST_WAIT;
          end
        end
        video_pkg::HOST_WAIT: begin
          if (crt_r.blank) host_r <= video_pkg::HOST_ACCESS;
        end
        video_pkg::HOST_ACCESS: begin
          if (host_load_r) begin
            host_r <= video_pkg::HOST_CAPTURE;
          end else begin
            ready_r <= 1'b1;
            host_r <= video_pkg::HOST_IDLE;
          end
        end
        video_pkg::HOST_CAPTURE: begin
          char_latch_r <= code_q;
          attr_latch_r <= attr_q;
          ready_r <= 1'b1;
          host_r <= video_pkg::HOST_IDLE;
        end
        default: host_r <= video_pkg::HOST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Display memories
  // ---------------------------------------------------------------
  logic [7:0] fount_q;
  logic fetch_go;
  logic fetch1_r;
  logic fetch2_r;
  logic [1:0] cur_d_r;
  logic [1:0] blank_d_r;
  logic [3:0] line_d_r;
  wire [11:0] cell_raddr = host_in_access ? mem_addr_r : crt_r.refresh_addr;
  wire [11:0] fount_raddr = {code_q, line_d_r};

  mem_dp #(.AW(video_pkg::ADDR_W), .DW(video_pkg::CODE_W)) u_char_mem (
    .clk(clk),
    .we(host_we),
    .waddr(mem_addr_r),
    .wdata(char_latch_r),
    .raddr(cell_raddr),
    .rdata(code_q)
  );

  mem_dp #(.AW(video_pkg::ADDR_W), .DW(video_pkg::CODE_W)) u_attr_mem (
    .clk(clk),
    .we(host_we),
    .waddr(mem_addr_r),
    .wdata(attr_latch_r),
    .raddr(cell_raddr),
    .rdata(attr_q)
  );

  mem_dp #(.AW(video_pkg::ADDR_W), .DW(video_pkg::CODE_W)) u_fount_mem (
    .clk(clk),
    .we(wr_fdata),
    .waddr(fount_addr_r),
    .wdata(wdata_m[7:0]),
    .raddr(fount_raddr),
    .rdata(fount_q)
  );

  // ---------------------------------------------------------------
  // Cell fetch pipeline into the FIFO
  // ---------------------------------------------------------------
  logic [7:0] attr_d_r;
  logic fifo_in_ready;
  logic [2:0] fifo_count;
  logic cell_valid;
  logic cell_pop;
  video_pkg::cell_s cell_out;
  wire video_pkg::cell_s cell_in = '{fount_q, attr_d_r, cur_d_r[1], blank_d_r[1]};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fetch1_r <= 1'b0;
      fetch2_r <= 1'b0;
      cur_d_r <= 2'b00;
      blank_d_r <= 2'b11;
      line_d_r <= 4'h0;
      attr_d_r <= 8'h00;
    end else begin
      fetch1_r <= fetch_go;
      fetch2_r <= fetch1_r;
      if (fetch_go) begin
        cur_d_r[0] <= crt_r.cursor;
        blank_d_r[0] <= crt_r.blank;
        line_d_r <= crt_r.line_num;
      end
      if (fetch1_r) begin
        cur_d_r[1] <= cur_d_r[0];
        blank_d_r[1] <= blank_d_r[0];
        attr_d_r <= attr_q;
      end
    end
  end

  // Two cells may be in flight, so a launch needs two free slots; a
  // starved shifter shows blank cells instead of stale glyphs.
  fifo_sync #(.W(video_pkg::CELL_W), .DEPTH(video_pkg::FIFO_DEPTH)) u_cell_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(fetch2_r),
    .in_ready(fifo_in_ready),
    .in_data(cell_in),
    .out_valid(cell_valid),
    .out_ready(cell_pop),
    .out_data(cell_out),
    .count(fifo_count)
  );
  assign fifo_empty = !cell_valid;

  // ---------------------------------------------------------------
  // Dot rate, character clock and shifter
  // ---------------------------------------------------------------
  logic [3:0] dot_acc_r;
  logic half_r;
  logic [3:0] col_r;
  logic [9:0] pix_r;
  logic hsync_d_r;
  video_pkg::cell_s cell_r;
  wire [3:0] dot_step = ctrl_r[video_pkg::CTRL_DOT_SEL] ? video_pkg::DOT_STEP_SLOW
                                                       : video_pkg::DOT_STEP_FAST;
  wire [4:0] dot_sum = {1'b0, dot_acc_r} + {1'b0, dot_step};
  wire dot_en = (dot_sum >= {1'b0, video_pkg::DOT_MOD});
  wire pix_en = dot_en && (!ctrl_r[video_pkg::CTRL_DOUBLE] || half_r);
  wire [3:0] width_raw = ctrl_r[video_pkg::CTRL_WIDTH_LSB +: 4];
  wire [3:0] cell_width = (width_raw < video_pkg::CELL_WIDTH_MIN) ? video_pkg::CELL_WIDTH_MIN
                                                                 : width_raw;
  wire col_last = (col_r == cell_width - 4'h1);
  wire char_tick = pix_en && col_last;
  wire line_start = crt_r.hsync && !hsync_d_r;
  wire [9:0] line_limit = ctrl_r[video_pkg::CTRL_DOT_SEL] ?
      (ctrl_r[video_pkg::CTRL_DOUBLE] ? video_pkg::LINE_PIX_DOUBLE : video_pkg::LINE_PIX_SLOW) :
      (ctrl_r[video_pkg::CTRL_COL132] ? video_pkg::LINE_PIX_132 : video_pkg::LINE_PIX_FAST);
  wire in_line = (pix_r < line_limit);
  wire dot_bit = (col_r < 4'h8) ? cell_r.dots[col_r[2:0]] : cell_r.dots[7];

  assign fetch_go = char_tick && (fifo_count < 3'(video_pkg::FIFO_DEPTH - 1)) && fifo_in_ready;
  assign cell_pop = char_tick && cell_valid;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dot_acc_r <= 4'h0;
      half_r <= 1'b0;
      col_r <= 4'h0;
      pix_r <= 10'h000;
      hsync_d_r <= 1'b0;
      cell_r <= '0;
    end else begin
      dot_acc_r <= dot_en ? 4'(dot_sum - {1'b0, video_pkg::DOT_MOD}) : dot_sum[3:0];
      hsync_d_r <= crt_r.hsync;
      if (dot_en) half_r <= !half_r;
      if (pix_en) begin
        col_r <= col_last ? 4'h0 : col_r + 4'h1;
        if (in_line) pix_r <= pix_r + 10'h001;
      end
      if (line_start) pix_r <= 10'h000;
      if (char_tick) begin
        cell_r <= cell_valid ? cell_out : video_pkg::cell_s'{8'h00, 8'h00, 1'b0, 1'b1};
      end
    end
  end

  // ---------------------------------------------------------------
  // Attribute decode and video outputs
  // ---------------------------------------------------------------
  // Mono attributes: bit 0 reverse, bit 1 underline on the last scan
  // line, bits 6 and 7 to green and intensity line; colour attributes: bits 2..0 fore RGB,
  // bits 5..3 back RGB, bit 6 intensity. Cursor inverts the cell.
  wire vis = in_line && !cell_r.blank;
  wire under = cell_r.attr[1] && (line_d_r == 4'hf);
  wire mono_dot = vis && ((dot_bit || under) ^ cell_r.attr[0] ^ cell_r.cursor);
  wire col_fg = vis && (dot_bit ^ cell_r.cursor);
  wire [2:0] rgb = col_fg ? cell_r.attr[2:0] : cell_r.attr[5:3];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      char_clk <= 1'b0;
      ttl_red <= 1'b0;
      ttl_green <= 1'b0;
      ttl_blue <= 1'b0;
      intensity_line <= 1'b0;
      video_dot <= 1'b0;
      composite_src <= 1'b0;
    end else begin
      char_clk <= (col_r < {1'b0, cell_width[3:1]});
      if (colour_mode) begin
        ttl_red <= vis && rgb[2];
        ttl_green <= vis && rgb[1];
        ttl_blue <= vis && rgb[0];
        intensity_line <= vis && cell_r.attr[6];
        video_dot <= vis && (rgb != 3'h0);
        composite_src <= vis && (rgb != 3'h0);
      end else begin
        ttl_red <= 1'b0;
        ttl_blue <= 1'b0;
        ttl_green <= cell_r.attr[6];
        intensity_line <= cell_r.attr[7];
        video_dot <= mono_dot;
        composite_src <= mono_dot;
      end
    end
  end

endmodule : char_video

// *** char_video_sva.sv ***
`timescale 1ns/1ps
module char_video_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic disp_blank,
  input wire logic switch_colour,
  input wire logic char_clk,
  input wire logic ttl_red,
  input wire logic ttl_blue,
  input wire logic video_dot
);
  // ---------------------------------------------------------------
  // Shadow state
  // ---------------------------------------------------------------
  logic [7:0] ctrl_r;
  logic [5:0] quiet_r;
  logic [6:0] blank_r;
  logic [3:0] mono_r;
  wire ctrl_touch = write && !waitrequest && address == video_pkg::REG_CTRL && byteenable[0];
  wire settled = quiet_r == 6'h3f;
  wire dflt = settled && ctrl_r == video_pkg::CTRL_RESET;
  wire mono = settled && !ctrl_r[video_pkg::CTRL_COLOUR_ESC] && mono_r == 4'hf;

  // Mode checks wait after a control write, since the column count carries over from the old mode.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= video_pkg::CTRL_RESET;
      quiet_r <= 6'h00;
    end else if (ctrl_touch) begin
      ctrl_r <= writedata[7:0];
      quiet_r <= 6'h00;
    end else if (!settled) begin
      quiet_r <= quiet_r + 6'h01;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      blank_r <= 7'h00;
      mono_r <= 4'h0;
    end else begin
      blank_r <= !disp_blank ? 7'h00 : ((blank_r == 7'h7f) ? blank_r : blank_r + 7'h01);
      mono_r <= switch_colour ? 4'h0 : ((mono_r == 4'hf) ? mono_r : mono_r + 4'h1);
    end
  end

  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_cc_high;
    char_clk [*4];
  endsequence
  sequence s_cc_low;
    !char_clk [*5];
  endsequence

  property p_wait_pulse;
    !waitrequest |=> waitrequest;
  endproperty
  a_wait_pulse: assert property (p_wait_pulse)
    else $error("waitrequest low for more than one cycle");
  property p_wait_answer;
    $rose(read || write) |=> !waitrequest;
  endproperty
  a_wait_answer: assert property (p_wait_answer)
    else $error("access not answered one cycle after request");
  property p_wait_idle;
    !(read || write) |=> waitrequest;
  endproperty
  a_wait_idle: assert property (p_wait_idle)
    else $error("waitrequest low without a request");
  property p_unmapped;
    read && !waitrequest && address > 4'h7 |-> readdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read returned nonzero data");
  property p_rd_hold;
    !read |=> $stable(readdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data changed without a read");
  property p_cc_min;
    $rose(char_clk) |-> char_clk [*3];
  endproperty
  a_cc_min: assert property (p_cc_min)
    else $error("character clock high phase too short");
  property p_cc_dflt;
    disable iff (rst || ctrl_touch) dflt && $rose(char_clk) |-> s_cc_high ##1 s_cc_low ##1 char_clk;
  endproperty
  a_cc_dflt: assert property (p_cc_dflt)
    else $error("character clock period differs from nine dots");
  property p_blank_dark;
    blank_r >= 7'h3c |-> !video_dot;
  endproperty
  a_blank_dark: assert property (p_blank_dark)
    else $error("video dot lit during blanking");
  property p_mono_rb;
    mono |-> !ttl_red && !ttl_blue;
  endproperty
  a_mono_rb: assert property (p_mono_rb)
    else $error("red or blue driven in monochrome mode");
endmodule : char_video_sva

bind char_video char_video_sva i_char_video_sva (
  .clk(clk), .rst(rst), .address(address), .read(read), .write(write),
  .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
  .waitrequest(waitrequest), .disp_blank(disp_blank), .switch_colour(switch_colour),
  .char_clk(char_clk), .ttl_red(ttl_red), .ttl_blue(ttl_blue), .video_dot(video_dot)
);

// *** crt_model.sv ***
`timescale 1ns/1ps
module crt_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic colour_sw,
  output video_pkg::crt_in_s crt
);
  // ---------------------------------------------------------------
  // Line timing: 160 cycles, 80 active then 80 blanked
  // ---------------------------------------------------------------
  logic [7:0] pos_r;
  logic [3:0] row_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pos_r <= 8'h00;
      row_r <= 4'h0;
    end else begin
      pos_r <= (pos_r == 8'h9f) ? 8'h00 : pos_r + 8'h01;
      row_r <= (pos_r == 8'h9f) ? row_r + 4'h1 : row_r;
    end
  end

  assign crt.hsync = pos_r < 8'h04;
  assign crt.blank = pos_r >= 8'h50;
  assign crt.refresh_addr = 12'(pos_r / 8'h09);
  assign crt.line_num = row_r;
  assign crt.cursor = 1'b0;
  assign crt.switch_colour = colour_sw;
endmodule : crt_model

// *** char_video_tb.sv ***
`timescale 1ns/1ps
module char_video_tb;
  logic clk = 1'b0;
  logic rst;
  logic [3:0] address;
  logic read;
  logic write;
  logic [3:0] byteenable;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic waitrequest;
  logic colour_sw;
  logic [31:0] q;
  logic char_clk, ttl_red, ttl_green, ttl_blue, intensity_line, video_dot, composite_src;
  video_pkg::crt_in_s crt;
  int errors;
  int samples_checked;
  int lit;

  always #50 clk = ~clk;

  crt_model i_crt_model (.clk(clk), .rst(rst), .colour_sw(colour_sw), .crt(crt));

  char_video i_char_video (
    .clk(clk), .rst(rst), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .refresh_addr(crt.refresh_addr), .line_num(crt.line_num),
    .disp_blank(crt.blank), .cursor(crt.cursor), .hsync(crt.hsync),
    .switch_colour(crt.switch_colour), .char_clk(char_clk), .ttl_red(ttl_red),
    .ttl_green(ttl_green), .ttl_blue(ttl_blue), .intensity_line(intensity_line),
    .video_dot(video_dot), .composite_src(composite_src)
  );

  // ---------------------------------------------------------------
  // Bus tasks
  // ---------------------------------------------------------------
  task automatic end_sim;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic acc(input logic wr_en, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= wr_en;
    read <= !wr_en;
    // The request stands until an edge sees waitrequest low; readdata is taken there.
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : acc

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    acc(1'b0, a, 32'h0);
    chk(q & m, e);
  endtask : rd

  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      acc(1'b0, video_pkg::REG_STATUS, 32'h0);
      n++;
    end while (q[video_pkg::STAT_READY] !== 1'b1 && n < 100);
    chk(q & 32'h1, 32'h1);
  endtask : wait_ready

  task automatic rate(input logic [31:0] c, input int lo, input int hi);
    int n;
    logic p;
    wr(video_pkg::REG_CTRL, c);
    n = 0;
    p = char_clk;
    repeat (990) begin
      @(negedge clk);
      if (char_clk === 1'b1 && p === 1'b0) n++;
      p = char_clk;
    end
    chk(32'(n >= lo && n <= hi), 32'h1);
  endtask : rate

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    #2000000;
    errors++;
    end_sim();
  end

  initial begin
    rst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 4'h0;
    byteenable = 4'hf;
    colour_sw = 1'b0;
    writedata = 32'h0;
    errors = 0;
    samples_checked = 0;
    lit = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd(video_pkg::REG_CTRL, 32'h90, 32'hff);
    rd(video_pkg::REG_STATUS, 32'h1, 32'h3);
    wr(4'hf, 32'hffffffff);
    rd(4'hf, 32'h0, 32'hffffffff);
    wr(video_pkg::REG_MEM_ADDR, 32'h0000fabc);
    rd(video_pkg::REG_MEM_ADDR, 32'habc, 32'hfff);
    wr(video_pkg::REG_FOUNT_ADDR, 32'h010);
    repeat (16) wr(video_pkg::REG_FOUNT_DATA, 32'hff);
    rd(video_pkg::REG_FOUNT_ADDR, 32'h020, 32'hfff);
    // The model walks refresh addresses 0 to 17, so every one of them is filled.
    for (int i = 0; i < 18; i++) begin
      wait_ready();
      wr(video_pkg::REG_CHAR_LATCH, 32'h01);
      wr(video_pkg::REG_ATTR_LATCH, 32'h40);
      wr(video_pkg::REG_MEM_ADDR, 32'(i));
      wr(video_pkg::REG_COMMAND, 32'(video_pkg::CMD_STORE));
    end
    wait_ready();
    wr(video_pkg::REG_CHAR_LATCH, 32'h00);
    wr(video_pkg::REG_ATTR_LATCH, 32'h00);
    wr(video_pkg::REG_MEM_ADDR, 32'h5);
    wr(video_pkg::REG_COMMAND, 32'(video_pkg::CMD_LOAD));
    wait_ready();
    rd(video_pkg::REG_CHAR_LATCH, 32'h01, 32'hff);
    rd(video_pkg::REG_ATTR_LATCH, 32'h40, 32'hff);
    repeat (480) @(posedge clk);
    repeat (320) begin
      @(negedge clk);
      if (video_dot === 1'b1) begin
        lit++;
      end
      chk({28'h0, ttl_green, intensity_line, ttl_red, composite_src ^ video_dot}, 32'h8);
    end
    chk(32'(lit > 64), 32'h1);
    rate(32'h90, 109, 111);
    rate(32'h91, 99, 101);
    rate(32'h93, 49, 51);
    colour_sw <= 1'b1;
    repeat (8) @(posedge clk);
    rd(video_pkg::REG_STATUS, 32'h2, 32'h2);
    colour_sw <= 1'b0;
    repeat (8) @(posedge clk);
    rd(video_pkg::REG_STATUS, 32'h0, 32'h2);
    wr(video_pkg::REG_CTRL, 32'h98);
    rd(video_pkg::REG_CTRL, 32'h98, 32'hff);
    repeat (8) @(posedge clk);
    rd(video_pkg::REG_STATUS, 32'h2, 32'h2);
    end_sim();
  end
endmodule : char_video_tb
